// ### gpio_indicator_defines.svh
// Timing constants and the pad count for the pad and indicator logic
`ifndef GPIO_INDICATOR_DEFINES_SVH
`define GPIO_INDICATOR_DEFINES_SVH
`define CLK_HZ            25000000
`define TXMON_LEAD_MS     300
`define TXMON_TAIL_MIN_MS 500
`define TXMON_TAIL_MAX_MS 1000
`define FAST_PERIOD_MS    1000
`define FAST_ON_MS        500
`define SLOW_PERIOD_MS    3000
`define SLOW_ON_MS        300
`define MS_CYCLES         (`CLK_HZ / 1000)
`define PAD_COUNT         13
`endif

// ### gpio_indicator_pkg.sv
// Types shared by the pad and indicator logic
package gpio_indicator_pkg;
  typedef enum logic [1:0] {
    PAD_INPUT  = 2'h0,
    PAD_OUTPUT = 2'h1,
    PAD_ALT    = 2'h2
  } pad_mode_t;
  typedef enum logic [1:0] {
    NET_OFF    = 2'h0,
    NET_SEARCH = 2'h1,
    NET_FULL   = 2'h2,
    NET_CALL   = 2'h3
  } net_state_t;
  typedef enum logic [1:0] {
    MON_IDLE = 2'h0,
    MON_LEAD = 2'h1,
    MON_CALL = 2'h2,
    MON_TAIL = 2'h3
  } mon_state_t;
endpackage

// ### gpio_indicator.sv
// Pad configuration, alternate functions and the network status indicator
`timescale 1ns/1ns
`default_nettype none
`include "gpio_indicator_defines.svh"

module gpio_indicator #(
  parameter int unsigned MS_CYC   = `MS_CYCLES,
  parameter int unsigned TONE_DIV = 12500
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic                     clk_en,
  // Pad configuration, per pad: 4..5 input-only pads, 0..3 and 6..12 general
  input  wire logic [2*`PAD_COUNT-1:0]  pad_mode_cfg,
  input  wire logic [`PAD_COUNT-1:0]    pad_out_wr,
  input  wire logic [`PAD_COUNT-1:0]    pad_out_val,
  input  wire logic [`PAD_COUNT-1:0]    alt_out,
  // Pad pins
  input  wire logic [`PAD_COUNT-1:0]    pad_in,
  output logic      [`PAD_COUNT-1:0]    pad_out,
  output logic      [`PAD_COUNT-1:0]    pad_oe,
  output logic      [`PAD_COUNT-1:0]    pad_read,
  // Transmitter control and status
  input  wire logic                     tx_burst,
  input  wire logic                     call_active,
  input  wire logic                     monitor_per_burst,
  output logic                          tx_enable,
  // Alarm and tone
  input  wire logic                     tone_role,
  input  wire logic                     alarm_event,
  input  wire logic                     alarm_clear,
  input  wire logic                     tone_on,
  // Network status
  input  wire gpio_indicator_pkg::net_state_t net_state
);
  localparam int unsigned PN = `PAD_COUNT;
  localparam int unsigned TX_INH = 6;
  localparam int unsigned TX_MON = 7;
  localparam int unsigned ALM    = 8;
  localparam int unsigned LED    = 9;
  localparam int unsigned LEAD_C  = `TXMON_LEAD_MS * MS_CYC;
  localparam int unsigned TAIL_C  = `TXMON_TAIL_MIN_MS * MS_CYC;
  localparam int unsigned FP_C    = `FAST_PERIOD_MS * MS_CYC;
  localparam int unsigned FON_C   = `FAST_ON_MS * MS_CYC;
  localparam int unsigned SP_C    = `SLOW_PERIOD_MS * MS_CYC;
  localparam int unsigned SON_C   = `SLOW_ON_MS * MS_CYC;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PN-1:0] sync1;
  logic [PN-1:0] sync2;
  logic          burst1, burst2;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1  <= '0;
      sync2  <= '0;
      burst1 <= 1'b0;
      burst2 <= 1'b0;
    end else if (clk_en) begin
      sync1  <= pad_in;
      sync2  <= sync1;
      burst1 <= tx_burst;
      burst2 <= burst1;
    end
  end

  // ----------------------------------------------------------------
  // Pad modes and latches
  // ----------------------------------------------------------------
  logic [PN-1:0] out_latch;
  logic [PN-1:0] alt_val;
  logic [PN-1:0] drive;
  logic [PN-1:0] is_out;
  logic [PN-1:0] is_alt;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) out_latch <= '0;
    else if (clk_en) out_latch <= (out_latch & ~pad_out_wr) | (pad_out_val & pad_out_wr);
  end

  for (genvar i = 0; i < PN; i++) begin : g_pad
    wire gpio_indicator_pkg::pad_mode_t m = gpio_indicator_pkg::pad_mode_t'(pad_mode_cfg[2*i +: 2]);
    // Every pad's pin is sensed, input-only pads 4 and 5 never drive
    wire in_only  = (i == 4) || (i == 5);
    assign is_out[i] = !in_only && (m == gpio_indicator_pkg::PAD_OUTPUT);
    assign is_alt[i] = (m == gpio_indicator_pkg::PAD_ALT) && (i != TX_INH) && !in_only;
    assign drive[i]  = is_alt[i] ? alt_val[i] : out_latch[i];
  end

  // Reads show the synchronised pin, two cycles late
  assign pad_read = sync2;

  // ----------------------------------------------------------------
  // Transmit inhibit
  // ----------------------------------------------------------------
  wire inhibit_role = (pad_mode_cfg[2*TX_INH +: 2] == gpio_indicator_pkg::PAD_ALT);
  assign tx_enable = !(inhibit_role && !sync2[TX_INH]);

  // ----------------------------------------------------------------
  // Transmit activity monitor
  // ----------------------------------------------------------------
  gpio_indicator_pkg::mon_state_t mstate;
  logic [31:0] mcnt;
  // Lead time needs call start ahead of the first burst; caller raises call_active early
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mstate <= gpio_indicator_pkg::MON_IDLE;
      mcnt   <= '0;
    end else if (clk_en) begin
      unique case (mstate)
        gpio_indicator_pkg::MON_IDLE: if (call_active) begin
          mstate <= gpio_indicator_pkg::MON_LEAD;
          mcnt   <= '0;
        end
        gpio_indicator_pkg::MON_LEAD: begin
          mcnt <= mcnt + 32'h1;
          if (mcnt + 32'h1 >= 32'(LEAD_C)) mstate <= gpio_indicator_pkg::MON_CALL;
        end
        gpio_indicator_pkg::MON_CALL: if (!call_active && !burst2) begin
          mstate <= gpio_indicator_pkg::MON_TAIL;
          mcnt   <= '0;
        end
        gpio_indicator_pkg::MON_TAIL: begin
          mcnt <= mcnt + 32'h1;
          if (burst2) mcnt <= '0;
          else if (mcnt + 32'h1 >= 32'(TAIL_C)) mstate <= gpio_indicator_pkg::MON_IDLE;
        end
      endcase
    end
  end
  wire mon_call  = (mstate != gpio_indicator_pkg::MON_IDLE);
  wire mon_level = monitor_per_burst ? burst2 : mon_call;

  // ----------------------------------------------------------------
  // Alarm and tone
  // ----------------------------------------------------------------
  logic        alarm;
  logic        tone;
  logic [31:0] tcnt;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm <= 1'b0;
      tone  <= 1'b0;
      tcnt  <= '0;
    end else if (clk_en) begin
      // Set wins over a clear in the same cycle
      if (alarm_event) alarm <= 1'b1;
      else if (alarm_clear) alarm <= 1'b0;
      if (!tone_on) begin
        tone <= 1'b0;
        tcnt <= '0;
      end else if (tcnt + 32'h1 >= 32'(TONE_DIV)) begin
        tone <= ~tone;
        tcnt <= '0;
      end else tcnt <= tcnt + 32'h1;
    end
  end
  wire alm_level = tone_role ? tone : alarm;

  // ----------------------------------------------------------------
  // Network status indicator
  // ----------------------------------------------------------------
  logic [31:0] bcnt;
  wire  fast = (net_state == gpio_indicator_pkg::NET_SEARCH);
  wire [31:0] period = fast ? 32'(FP_C) : 32'(SP_C);
  wire [31:0] on_len = fast ? 32'(FON_C) : 32'(SON_C);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) bcnt <= '0;
    else if (clk_en) bcnt <= (bcnt + 32'h1 >= period) ? '0 : bcnt + 32'h1;
  end
  logic lamp;
  always_comb begin
    unique case (net_state)
      gpio_indicator_pkg::NET_OFF:    lamp = 1'b0;
      gpio_indicator_pkg::NET_SEARCH: lamp = bcnt < on_len;
      gpio_indicator_pkg::NET_FULL:   lamp = bcnt < on_len;
      gpio_indicator_pkg::NET_CALL:   lamp = 1'b1;
    endcase
  end

  // Alternate values: pads 7, 8 and 9 carry monitor, alarm and inverted lamp; the others come from alt_out
  always_comb begin
    alt_val         = alt_out;
    alt_val[TX_MON] = mon_level;
    alt_val[ALM]    = alm_level;
    alt_val[LED]    = !lamp;
  end

  // ----------------------------------------------------------------
  // Pad drivers, registered, push-pull
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_out <= '0;
      pad_oe  <= '0;
    end else if (clk_en) begin
      pad_out <= drive;
      pad_oe  <= is_out | is_alt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  reset_idle_a: assert property (@(posedge core_clk) $rose(rst_b) |-> pad_oe == '0)
    else $error("pads not input after reset");
  // Checked from the pin, so a broken synchroniser shows up here too
  inhibit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $past(clk_en) && $past(clk_en, 2) && inhibit_role && !$past(pad_in[TX_INH], 2)
    |-> !tx_enable)
    else $error("transmitter not inhibited");
  sequence call_start_s;
    clk_en && mstate == gpio_indicator_pkg::MON_IDLE && call_active;
  endsequence
  lead_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    call_start_s |=> mstate == gpio_indicator_pkg::MON_LEAD)
    else $error("monitor lead not started");
  burst_track_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && monitor_per_burst && is_alt[TX_MON] |=> pad_out[TX_MON] == $past(burst2))
    else $error("burst not tracked");
  alarm_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && alarm && !alarm_clear |=> alarm)
    else $error("alarm dropped without clear");
  alarm_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && alarm_event |=> alarm)
    else $error("alarm not set");
  led_call_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && is_alt[LED] && net_state == gpio_indicator_pkg::NET_CALL |=> !pad_out[LED])
    else $error("indicator not on in call");
  led_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && is_alt[LED] && net_state == gpio_indicator_pkg::NET_OFF |=> pad_out[LED])
    else $error("indicator not off");
  // A frozen counter may sit past a shorter period until the clock runs again
  blink_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && $past(clk_en) |-> bcnt < period || !$stable(net_state))
    else $error("blink counter past period");
  pad_drive_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && is_out[0] && !is_alt[0] |=> pad_oe[0] && pad_out[0] == $past(out_latch[0]))
    else $error("output pad not driven");
endmodule
`default_nettype wire

// ### gpio_host_model.sv
// Host-side model: external pad drivers and the indicator lamp transistor
`timescale 1ns/1ns
`default_nettype none
module gpio_host_model (
  // Pad pins
  input  wire logic [12:0] pad_out,
  input  wire logic [12:0] pad_oe,
  // Host drive
  input  wire logic [12:0] ext_drive,
  input  wire logic [12:0] ext_val,
  output logic      [12:0] pad_in,
  output logic             lamp_on
);
  // Undriven pads show the inverse of the latch, so a floating pin never looks settled
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drive & ext_val)
                | (~pad_oe & ~ext_drive & ~pad_out);
  // Lamp transistor inverts the indicator pin
  assign lamp_on = ~pad_out[9];
endmodule
`default_nettype wire

// ### gpio_indicator_tb.sv
// Self-checking bench for the pad and indicator logic
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin miscompares++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module gpio_indicator_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic core_clk = 0, rst_b = 0, tx_burst = 0, call_active = 0, per_burst = 0;
  logic tone_role = 0, alarm_event = 0, alarm_clear = 0, tone_on = 0, lamp_on, tx_enable;
  logic prev, clk_en = 1;
  logic [25:0] cfg = '0;
  logic [12:0] wr = '0, val = '0, alt = '0, ext_drv = '0, ext_val = '0;
  logic [12:0] pad_in, pad_out, pad_oe, pad_read;
  gpio_indicator_pkg::net_state_t net = gpio_indicator_pkg::NET_OFF;
  int miscompares = 0, cmp_count = 0, cyc = 0, n;
  always #20 core_clk = ~core_clk;
  gpio_indicator #(.MS_CYC(10), .TONE_DIV(5)) dut (.core_clk(core_clk), .rst_b(rst_b),
    .clk_en(clk_en), .pad_mode_cfg(cfg), .pad_out_wr(wr), .pad_out_val(val), .alt_out(alt),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_read(pad_read),
    .tx_burst(tx_burst), .call_active(call_active), .monitor_per_burst(per_burst),
    .tx_enable(tx_enable), .tone_role(tone_role), .alarm_event(alarm_event),
    .alarm_clear(alarm_clear), .tone_on(tone_on), .net_state(net));
  gpio_host_model host (.pad_out(pad_out), .pad_oe(pad_oe), .ext_drive(ext_drv),
    .ext_val(ext_val), .pad_in(pad_in), .lamp_on(lamp_on));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #2;
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 70000) begin
      miscompares++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic out_pads;
    cfg[1:0] = 2'h1; cfg[9:8] = 2'h1; cfg[21:20] = 2'h2; alt[10] = 1'b1;
    wr[0] = 1'b1; val[0] = 1'b1; wr[4] = 1'b1; val[4] = 1'b1;
    tick(1); wr = '0;
    tick(1);
    `CHK("oe0", 1'b1, pad_oe[0])
    `CHK("out0", 1'b1, pad_out[0])
    `CHK("oe4", 1'b0, pad_oe[4])
    `CHK("alt10", 1'b1, pad_out[10])
    wr[0] = 1'b1; val[0] = 1'b0;
    tick(1); wr = '0;
    tick(1);
    `CHK("low0", 2'h1, {pad_out[0], pad_oe[0]})
    clk_en = 1'b0; wr[0] = 1'b1; val[0] = 1'b1; tick(2);
    `CHK("frz", 1'b0, pad_out[0])
    wr = '0; clk_en = 1'b1; tick(2);
    `CHK("held", 1'b0, pad_out[0])
  endtask
  task automatic in_pads;
    ext_drv[5] = 1'b1; ext_val[5] = 1'b0; tick(3);
    `CHK("rd5l", 1'b0, pad_read[5])
    ext_val[5] = 1'b1; tick(3);
    `CHK("rd5h", 1'b1, pad_read[5])
  endtask
  task automatic inhibit;
    cfg[13:12] = 2'h2; ext_drv[6] = 1'b1; ext_val[6] = 1'b0; tick(4);
    `CHK("txoff", 1'b0, tx_enable)
    ext_val[6] = 1'b1; tick(4);
    `CHK("txon", 1'b1, tx_enable)
  endtask
  task automatic monitor;
    cfg[15:14] = 2'h2; per_burst = 1'b1; tx_burst = 1'b1; tick(5);
    `CHK("burst", 1'b1, pad_out[7])
    tx_burst = 1'b0; tick(5);
    `CHK("gap", 1'b0, pad_out[7])
    per_burst = 1'b0; call_active = 1'b1; tick(5);
    `CHK("lead", 1'b1, pad_out[7])
    // Lead 300 ms plus tail 500 ms at 10 cycles per ms: low about 8000 cycles on
    call_active = 1'b0; tick(7990);
    `CHK("tail", 1'b1, pad_out[7])
    tick(20);
    `CHK("done", 1'b0, pad_out[7])
  endtask
  task automatic alarm_tone;
    cfg[17:16] = 2'h2; alarm_event = 1'b1; tick(1); alarm_event = 1'b0; tick(30);
    `CHK("alarm", 1'b1, pad_out[8])
    alarm_clear = 1'b1; tick(1); alarm_clear = 1'b0; tick(2);
    `CHK("clr", 1'b0, pad_out[8])
    tone_role = 1'b1; tone_on = 1'b1; tick(3); n = 0; prev = pad_out[8];
    repeat (40) begin
      tick(1);
      if (pad_out[8] !== prev) n++;
      prev = pad_out[8];
    end
    `CHK("tone", 40 / 5, n)
  endtask
  task automatic lamp(input gpio_indicator_pkg::net_state_t s, input int per, input int on);
    net = s; tick(4); n = 0;
    repeat (per) begin
      tick(1);
      if (lamp_on === 1'b1) n++;
    end
    `CHK("lamp", on, n)
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    // Pads are judged only after release has settled, so power-up glitches pass unseen
    tick(10); rst_b = 1'b1; tick(2);
    `CHK("rst_oe", 13'h0, pad_oe)
    `CHK("rst_out", 13'h0, pad_out)
    out_pads(); in_pads(); inhibit(); monitor(); alarm_tone();
    cfg[19:18] = 2'h2;
    lamp(gpio_indicator_pkg::NET_OFF, 100, 0);
    lamp(gpio_indicator_pkg::NET_CALL, 100, 100);
    lamp(gpio_indicator_pkg::NET_SEARCH, 10000, 5000);
    lamp(gpio_indicator_pkg::NET_FULL, 30000, 3000);
    conclude();
  end
endmodule
`default_nettype wire
